// [pkg/ssu_pkg.sv]
// constants for the shift and scale unit
package ssu_pkg;
   localparam int WORD_W = 36;
   localparam int DWORD_W = 72;
   localparam int CNT_W = 7;
   localparam int RADDR_W = 7;
   // function code of the shift group and its minor codes
   localparam logic [5:0] FUNC_SHIFT = 6'h3B;
   localparam logic [3:0] MIN_DRSF = 4'h5;
   localparam logic [3:0] MIN_SNC = 4'h6;
   localparam logic [3:0] MIN_DNC = 4'h7;
   localparam logic [3:0] MIN_SLR = 4'h8;
   localparam logic [3:0] MIN_DLR = 4'h9;
   localparam logic [3:0] MIN_SLZ = 4'hA;
   localparam logic [3:0] MIN_DLZ = 4'hB;
   // control registers standing in past the last accumulator
   localparam logic [RADDR_W-1:0] CR_LOW = 7'h1C;
   localparam logic [RADDR_W-1:0] CR_HIGH = 7'h7C;
   localparam logic [4:0] ACC_COUNT = 5'h10;
   localparam logic [3:0] SEL_LAST = 4'hF;
   localparam logic [3:0] SEL_PENULT = 4'hE;
   localparam logic [CNT_W-1:0] HALF_ROT = 7'h24;
   localparam logic [CNT_W-1:0] MAX_CNT = 7'h48;
   localparam logic [WORD_W-1:0] SNC_ZERO_CNT = 36'h23;
   localparam logic [WORD_W-1:0] DNC_ZERO_CNT = 36'h47;
   localparam logic [2:0] WEN_ONE = 3'h1;
   localparam logic [2:0] WEN_TWO = 3'h3;
   localparam logic [2:0] WEN_THREE = 3'h7;
endpackage

// [hdl/ssu_core.sv]
// shift and scale datapath: double signfill shift, normalise and count, left shifts
`timescale 1ns/1ps
`default_nettype none
module ssu_core #(
   parameter logic [6:0] A_BASE = 7'h0C
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic [5:0] req_func,
   input wire logic [3:0] req_minor,
   input wire logic [17:0] req_addr,
   input wire logic [3:0] selected_accumulator,
   input wire logic cr_bank_high,
   input wire logic [35:0] op_hi,
   input wire logic [35:0] op_lo,
   output logic done,
   output logic [2:0] wr_en,
   output logic [6:0] wr_addr0,
   output logic [6:0] wr_addr1,
   output logic [6:0] wr_addr2,
   output logic [35:0] wr_data0,
   output logic [35:0] wr_data1,
   output logic [35:0] wr_data2
);
   typedef struct packed {
      logic done;
      logic [2:0] wen;
      logic [6:0] a0;
      logic [6:0] a1;
      logic [6:0] a2;
      logic [35:0] d0;
      logic [35:0] d1;
      logic [35:0] d2;
   } ssu_state_s;

   ssu_state_s st_q;
   ssu_state_s st_d;

   // sixteen accumulators must fit below the top of the 7-bit register space
   if (A_BASE > 7'h70) begin
      $error("ssu_core: accumulator base leaves no room for sixteen accumulators");
   end

   // register file address of accumulator a+k, past the last one into control space
   function automatic logic [6:0] rf_addr(input logic [3:0] a, input logic [1:0] k, input logic bank);
      logic [4:0] sum;
      sum = {1'b0, a} + {3'b000, k};
      if (sum < ssu_pkg::ACC_COUNT) begin
         rf_addr = A_BASE + {2'b00, sum};
      end else begin
         rf_addr = (bank ? ssu_pkg::CR_HIGH : ssu_pkg::CR_LOW) + {2'b00, sum - ssu_pkg::ACC_COUNT};
      end
   endfunction

   // fewest left rotations making the top two bits differ; all equal gives width-1
   function automatic logic [6:0] norm_cnt72(input logic [71:0] v, input logic dbl);
      logic [6:0] c;
      c = dbl ? 7'(ssu_pkg::DNC_ZERO_CNT) : 7'(ssu_pkg::SNC_ZERO_CNT);
      for (int i = 0; i < 71; i++) begin
         if (dbl) begin
            if (v[i+1] != v[i]) begin
               c = 7'(70 - i);
            end
         end else if (i < 35) begin
            if (v[i+1] != v[i]) begin
               c = 7'(34 - i);
            end
         end
      end
      norm_cnt72 = c;
   endfunction

   function automatic logic [71:0] rotl72(input logic [71:0] v, input logic [6:0] c);
      logic [143:0] t;
      t = {v, v} << c;
      rotl72 = t[143:72];
   endfunction

   function automatic logic [35:0] rotl36(input logic [35:0] v, input logic [6:0] c);
      logic [71:0] t;
      t = {v, v} << c;
      rotl36 = t[71:36];
   endfunction

   logic [6:0] cnt;
   logic [71:0] pair;
   logic [6:0] single_cnt;
   logic [6:0] sn_cnt;
   logic [6:0] dn_cnt;
   logic [71:0] dres;
   logic [35:0] sres;

   assign cnt = req_addr[6:0];
   assign pair = {op_hi, op_lo};
   // counts 36..72 behave as count-36 for a single-word rotate
   assign single_cnt = (cnt >= ssu_pkg::HALF_ROT) ? cnt - ssu_pkg::HALF_ROT : cnt;
   // single word sits in the low half, where the single-width scan looks
   assign sn_cnt = norm_cnt72({36'h0, op_hi}, 1'b0);
   assign dn_cnt = norm_cnt72(pair, 1'b1);

   always_comb begin
      st_d = st_q;
      st_d.done = 1'b0;
      st_d.wen = 3'b000;
      dres = '0;
      sres = '0;
      // only the shift group codes act; anything else leaves the register file alone
      if (req_valid && req_func == ssu_pkg::FUNC_SHIFT) begin
         st_d.a0 = rf_addr(selected_accumulator, 2'd0, cr_bank_high);
         st_d.a1 = rf_addr(selected_accumulator, 2'd1, cr_bank_high);
         st_d.a2 = rf_addr(selected_accumulator, 2'd2, cr_bank_high);
         case (req_minor)
            ssu_pkg::MIN_DRSF: begin
               // arithmetic shift replicates bit 35 of the upper word; counts past 72 undefined
               dres = 72'($signed(pair) >>> cnt);
               st_d.wen = ssu_pkg::WEN_TWO;
               st_d.d0 = dres[71:36];
               st_d.d1 = dres[35:0];
               st_d.done = 1'b1;
            end
            ssu_pkg::MIN_SNC: begin
               // all-zero and all-ones rotate to themselves, so no special path needed
               sres = rotl36(op_hi, sn_cnt);
               st_d.wen = ssu_pkg::WEN_TWO;
               st_d.d0 = sres;
               st_d.d1 = {29'h0, sn_cnt};
               st_d.done = 1'b1;
            end
            ssu_pkg::MIN_DNC: begin
               dres = rotl72(pair, dn_cnt);
               st_d.wen = ssu_pkg::WEN_THREE;
               st_d.d0 = dres[71:36];
               st_d.d1 = dres[35:0];
               st_d.d2 = {29'h0, dn_cnt};
               st_d.done = 1'b1;
            end
            ssu_pkg::MIN_SLR: begin
               st_d.wen = ssu_pkg::WEN_ONE;
               st_d.d0 = rotl36(op_hi, single_cnt);
               st_d.done = 1'b1;
            end
            ssu_pkg::MIN_DLR: begin
               dres = rotl72(pair, cnt);
               st_d.wen = ssu_pkg::WEN_TWO;
               st_d.d0 = dres[71:36];
               st_d.d1 = dres[35:0];
               st_d.done = 1'b1;
            end
            ssu_pkg::MIN_SLZ: begin
               // a shift of 36 or more empties the word
               sres = (cnt >= ssu_pkg::HALF_ROT) ? 36'h0 : op_hi << cnt;
               st_d.wen = ssu_pkg::WEN_ONE;
               st_d.d0 = sres;
               st_d.done = 1'b1;
            end
            ssu_pkg::MIN_DLZ: begin
               dres = pair << cnt;
               st_d.wen = ssu_pkg::WEN_TWO;
               st_d.d0 = dres[71:36];
               st_d.d1 = dres[35:0];
               st_d.done = 1'b1;
            end
            default: begin
               // unused minor codes keep the last addresses standing
               st_d.a0 = st_q.a0;
               st_d.a1 = st_q.a1;
               st_d.a2 = st_q.a2;
               st_d.wen = 3'b000;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign done = st_q.done;
   assign wr_en = st_q.wen;
   assign wr_addr0 = st_q.a0;
   assign wr_addr1 = st_q.a1;
   assign wr_addr2 = st_q.a2;
   assign wr_data0 = st_q.d0;
   assign wr_data1 = st_q.d1;
   assign wr_data2 = st_q.d2;

   // assertions
   sequence s_op(logic [3:0] m);
      req_valid && req_func == ssu_pkg::FUNC_SHIFT && req_minor == m;
   endsequence

   a_signfill_top: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_op(ssu_pkg::MIN_DRSF) ##0 (req_addr[6:0] == 7'h24) |=> wr_data0 == {36{$past(op_hi[35])}})
      else $error("signfill shift by 36 did not fill upper word with sign");

   a_count_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_op(ssu_pkg::MIN_DLZ) ##0 (req_addr[6:0] == 7'h01) && (req_addr[17:7] != 11'h0)
      |=> wr_data1 == {$past(op_lo[34:0]), 1'b0})
      else $error("shift count not taken from low seven address bits");

   a_pair_ctrl_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_op(ssu_pkg::MIN_DLR) ##0 selected_accumulator == ssu_pkg::SEL_LAST
      |=> wr_en[1] && wr_addr1 == ($past(cr_bank_high) ? ssu_pkg::CR_HIGH : ssu_pkg::CR_LOW))
      else $error("second word of selector 17 not in control register");

   a_snc_scaled: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_op(ssu_pkg::MIN_SNC) ##0 (op_hi[35] != op_hi[34])
      |=> wr_data0 == $past(op_hi) && wr_data1 == 36'h0)
      else $error("scaled single word was altered or count nonzero");

   a_snc_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_op(ssu_pkg::MIN_SNC) ##0 (op_hi == 36'h0 || op_hi == 36'hFFFFFFFFF)
      |=> wr_data1 == ssu_pkg::SNC_ZERO_CNT && wr_data0 == $past(op_hi))
      else $error("single zero word count is not 35");

   a_snc_result: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_op(ssu_pkg::MIN_SNC) ##1 done |-> (wr_data0[35] != wr_data0[34] && wr_data1 < ssu_pkg::SNC_ZERO_CNT) ||
      (wr_data1 == ssu_pkg::SNC_ZERO_CNT && (wr_data0 == 36'h0 || wr_data0 == 36'hFFFFFFFFF)))
      else $error("normalised single word top bits still equal");

   a_dnc_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_op(ssu_pkg::MIN_DNC) ##0 ({op_hi, op_lo} == 72'h0)
      |=> wr_en == 3'h7 && wr_data2 == ssu_pkg::DNC_ZERO_CNT && wr_data0 == 36'h0)
      else $error("double zero word count is not 71");

   a_dnc_count_reg: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_op(ssu_pkg::MIN_DNC) ##0 selected_accumulator == ssu_pkg::SEL_PENULT
      |=> wr_addr2 == ($past(cr_bank_high) ? ssu_pkg::CR_HIGH : ssu_pkg::CR_LOW))
      else $error("double normalise count not in control register");

   a_rotate_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_op(ssu_pkg::MIN_SLR) ##0 (req_addr[6:0] == ssu_pkg::MAX_CNT) |=> wr_data0 == $past(op_hi))
      else $error("single rotate by 72 changed the word");

   a_zerofill_big: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_op(ssu_pkg::MIN_SLZ) ##0 (req_addr[6:0] >= 7'h24) && (req_addr[6:0] <= 7'h48)
      |=> wr_en == 3'h1 && wr_data0 == 36'h0)
      else $error("left zerofill by 36..72 is not zero");

   a_unused_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !(req_valid && req_func == ssu_pkg::FUNC_SHIFT && req_minor >= 4'h5 && req_minor <= 4'hB)
      |=> wr_en == 3'h0 && !done)
      else $error("unused code caused a register write");

   a_dnc_scaled: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_op(ssu_pkg::MIN_DNC) ##0 (op_hi[35] != op_hi[34])
      |=> wr_data0 == $past(op_hi) && wr_data1 == $past(op_lo) && wr_data2 == 36'h0)
      else $error("scaled double word was altered or count nonzero");

   a_zerofill_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_op(ssu_pkg::MIN_DLZ) ##0 (req_addr[6:0] == ssu_pkg::MAX_CNT)
      |=> wr_en == 3'h3 && wr_data0 == 36'h0 && wr_data1 == 36'h0)
      else $error("double zerofill by 72 left bits behind");

   a_zerofill_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_op(ssu_pkg::MIN_SLZ) ##0 (req_addr[6:0] == 7'h01)
      |=> wr_data0 == {$past(op_hi[34:0]), 1'b0})
      else $error("single zerofill by one is not a one-place shift");
endmodule
`default_nettype wire

// [testbench/ssu_regfile_model.sv]
// register file model receiving the unit's result writes
`timescale 1ns/1ps
`default_nettype none
module ssu_regfile_model (
   input wire logic sys_clk,
   input wire logic [2:0] wr_en,
   input wire logic [6:0] wr_addr0,
   input wire logic [6:0] wr_addr1,
   input wire logic [6:0] wr_addr2,
   input wire logic [35:0] wr_data0,
   input wire logic [35:0] wr_data1,
   input wire logic [35:0] wr_data2
);
   logic [35:0] mem [128];
   // no index incrementation here, so the h/x pairings never arise
   always_ff @(posedge sys_clk) begin
      if (wr_en[0]) mem[wr_addr0] <= wr_data0;
      if (wr_en[1]) mem[wr_addr1] <= wr_data1;
      if (wr_en[2]) mem[wr_addr2] <= wr_data2;
   end
endmodule
`default_nettype wire

// [testbench/test_shift_and_scale_unit.sv]
// self-checking bench for the shift and scale unit
`timescale 1ns/1ps
`default_nettype none
module test_shift_and_scale_unit;
   localparam logic [6:0] A_BASE_TB = 7'h0C;
   logic sys_clk, rst_n, req_valid, cr_bank_high, done, e_done, t_done, s_v, s_b;
   logic [5:0] req_func, s_fn;
   logic [3:0] req_minor, selected_accumulator, s_mi, s_a;
   logic [17:0] req_addr, s_ad;
   logic [35:0] op_hi, op_lo, s_hi, s_lo, wr_data0, wr_data1, wr_data2;
   logic [2:0] wr_en, e_wen, t_wen;
   logic [6:0] wr_addr0, wr_addr1, wr_addr2, c;
   logic [6:0] e_a [3], t_a [3];
   logic [35:0] e_d [3], t_d [3];
   logic [31:0] seed;
   int n_mismatch, num_checks, cyc, i;
   ssu_core #(.A_BASE(A_BASE_TB)) ssu_core_inst (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_func(req_func), .req_minor(req_minor), .req_addr(req_addr),
      .selected_accumulator(selected_accumulator), .cr_bank_high(cr_bank_high), .op_hi(op_hi),
      .op_lo(op_lo), .done(done), .wr_en(wr_en), .wr_addr0(wr_addr0), .wr_addr1(wr_addr1),
      .wr_addr2(wr_addr2), .wr_data0(wr_data0), .wr_data1(wr_data1), .wr_data2(wr_data2));
   ssu_regfile_model ssu_regfile_model_inst (.sys_clk(sys_clk), .wr_en(wr_en), .wr_addr0(wr_addr0),
      .wr_addr1(wr_addr1), .wr_addr2(wr_addr2), .wr_data0(wr_data0), .wr_data1(wr_data1),
      .wr_data2(wr_data2));
   // sixteen galois steps per draw so consecutive draws are less correlated
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      for (int j = 0; j < 16; j++) s = s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
      return s;
   endfunction
   task automatic calc(input logic v, input logic [5:0] fn, input logic [3:0] mi, input logic [6:0] cn,
      input logic [3:0] a, input logic b, input logic [35:0] hi, input logic [35:0] lo);
      logic [71:0] x;
      logic [35:0] r;
      int n;
      x = {hi, lo};
      r = hi;
      n = 0;
      for (int k = 0; k < 3; k++) begin
         t_a[k] = (a + k < 16) ? 7'(A_BASE_TB + a + k) : 7'((b ? ssu_pkg::CR_HIGH : ssu_pkg::CR_LOW) + a + k - 16);
      end
      t_done = v && fn === ssu_pkg::FUNC_SHIFT && mi >= 4'h5 && mi <= 4'hB;
      t_wen = 3'h0;
      t_d[2] = 36'h0;
      if (t_done) begin
         case (mi)
            4'h5: begin
               for (int k = 0; k < cn; k++) x = {x[71], x[71:1]};
               t_wen = 3'h3;
            end
            // all-same words stop at 35/71 rotations, which leave them unchanged
            4'h6: begin
               for (n = 0; n < 35 && r[35] == r[34]; n++) r = {r[34:0], r[35]};
               x = {r, 36'(n)};
               t_wen = 3'h3;
            end
            4'h7: begin
               for (n = 0; n < 71 && x[71] == x[70]; n++) x = {x[70:0], x[71]};
               t_d[2] = 36'(n);
               t_wen = 3'h7;
            end
            4'h8: begin
               for (int k = 0; k < cn % 36; k++) r = {r[34:0], r[35]};
               x[71:36] = r;
               t_wen = 3'h1;
            end
            4'h9: begin
               for (int k = 0; k < cn % 72; k++) x = {x[70:0], x[71]};
               t_wen = 3'h3;
            end
            4'hA: begin x[71:36] = hi << cn; t_wen = 3'h1; end
            default: begin x = x << cn; t_wen = 3'h3; end
         endcase
      end
      t_d[0] = x[71:36];
      t_d[1] = x[35:0];
   endtask
   task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, seen);
         n_mismatch++;
      end
   endtask
   task automatic chk_word(input int w, input logic [6:0] ad, input logic [35:0] dt);
      if (e_wen[w] === 1'b1) begin
         chk("wr_addr", 36'(ad), 36'(e_a[w]));
         chk("wr_data", dt, e_d[w]);
      end
   endtask
   task automatic complete_run;
      $display("mismatches %0d checks %0d", n_mismatch, num_checks);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 3000) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      rst_n = 1'b0;
      {req_valid, req_func, req_minor, req_addr, selected_accumulator, cr_bank_high, op_hi, op_lo} = '0;
      seed = 32'hE9A3C192;
      e_done = 1'b0;
      e_wen = 3'h0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (i = 0; i < 1500; i++) begin
         seed = lfsr(seed);
         s_hi = {seed[3:0], seed};
         seed = lfsr(seed);
         s_lo = {seed, seed[31:28]};
         seed = lfsr(seed);
         case (seed[2:0])
            3'h0: begin s_hi = '0; s_lo = '0; end
            3'h1: begin s_hi = '1; s_lo = '1; end
            3'h2: s_hi = {2'h1, s_hi[33:0]};
            3'h3: s_hi = 36'(seed[8:3]);
            3'h4: s_hi = '1;
            default: ;
         endcase
         // stimulus keeps counts at 72 or below
         c = seed[4:3] == 2'h0 ? 7'h48 : seed[4:3] == 2'h1 ? 7'h24 : 7'(seed[14:8] % 73);
         // a count of one now and then exercises the single-step shifts
         if (seed[4:3] == 2'h2 && seed[15]) c = 7'h01;
         s_ad = {seed[31:21], c};
         s_mi = seed[19:16];
         s_fn = seed[23:20] == 4'h0 ? 6'h3A : ssu_pkg::FUNC_SHIFT;
         s_a = seed[27:24];
         s_b = seed[28];
         s_v = seed[29] | seed[30];
         calc(s_v, s_fn, s_mi, c, s_a, s_b, s_hi, s_lo);
         @(posedge sys_clk);
         req_valid <= s_v;
         req_func <= s_fn;
         req_minor <= s_mi;
         req_addr <= s_ad;
         selected_accumulator <= s_a;
         cr_bank_high <= s_b;
         op_hi <= s_hi;
         op_lo <= s_lo;
         #1;
         chk("done", 36'(done), 36'(e_done));
         chk("wr_en", 36'(wr_en), 36'(e_wen));
         chk_word(0, wr_addr0, wr_data0);
         chk_word(1, wr_addr1, wr_data1);
         chk_word(2, wr_addr2, wr_data2);
         e_done = t_done;
         e_wen = t_wen;
         e_a = t_a;
         e_d = t_d;
      end
      // last request's answer, then its landing in the register file
      @(posedge sys_clk);
      req_valid <= 1'b0;
      #1;
      chk("done", 36'(done), 36'(e_done));
      chk_word(0, wr_addr0, wr_data0);
      chk_word(1, wr_addr1, wr_data1);
      chk_word(2, wr_addr2, wr_data2);
      @(posedge sys_clk);
      #1;
      for (i = 0; i < 3; i++) begin
         if (e_wen[i] === 1'b1) begin
            chk("stored", ssu_regfile_model_inst.mem[e_a[i]], e_d[i]);
         end
      end
      complete_run();
   end
endmodule
`default_nettype wire
